// ---- dv/apd_core_properties.sv ----
/* Port checker for apd_core.
   Assumes host pins idle at reset and pulses of the async pins of 8+ cycles. */
`timescale 1ns/1ns
module apd_core_properties (
    // clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pready_o,
    input wire pslverr_o,
    // pins
    input wire chip_select_n_i,
    input wire shutdown_pin_n_i,
    input wire serial_data_out_oe_o,
    input wire conversion_strobe_o,
    // power enables
    input wire converter_en_o,
    input wire bandgap_en_o,
    input wire ref_buffer_en_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_shutdown_pin_n_held;
        !shutdown_pin_n_i [*8];
    endsequence
    a_ready_single: assert property (s_access |=> pready_o ##1 !pready_o)
        else $error("apb answer not one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
    a_bandgap_kept: assert property (bandgap_en_o)
        else $error("bandgap disabled");
    a_full_pd_order: assert property (!ref_buffer_en_o |-> !converter_en_o)
        else $error("buffer off while converter on");
    a_shutdown_pin_n_forces: assert property (s_shutdown_pin_n_held |-> !converter_en_o
        && !ref_buffer_en_o && conversion_strobe_o)
        else $error("shutdown not forcing full power-down");
    // sync delay of the pin is covered by the 4-cycle look-back
    a_busy_powered: assert property (!conversion_strobe_o && shutdown_pin_n_i
        && $past(shutdown_pin_n_i, 4) |-> converter_en_o)
        else $error("converter off mid conversion");
    a_wake_on_start: assert property ($fell(conversion_strobe_o)
        |-> converter_en_o && ref_buffer_en_o)
        else $error("conversion without wake");
    a_oe_selected: assert property (!chip_select_n_i [*6] |-> serial_data_out_oe_o)
        else $error("data out not driven while selected");
    a_oe_released: assert property (chip_select_n_i [*6] |-> !serial_data_out_oe_o)
        else $error("data out driven while deselected");
    a_reset_state: assert property ($fell(reset_i) |-> converter_en_o
        && ref_buffer_en_o && conversion_strobe_o && !pready_o)
        else $error("wrong state after reset");
endmodule // apd_core_properties

// ---- dv/apd_host_model.sv ----
/* Host side of the serial control link.
   Assumes the bench calls its tasks one at a time, clocked by sys_clk_i. */
`timescale 1ns/1ns
module apd_host_model (
    // clock
    input  wire sys_clk_i,
    // pins driven by the host
    output reg  cs_n_o,
    output reg  sclk_o,
    output reg  din_o,
    output reg  shutdown_pin_n_n_o,
    // result line
    input  wire dout_i
);
    // pins idle until the bench starts a frame
    initial begin
        cs_n_o   = 1'b1;
        sclk_o   = 1'b0;
        din_o    = 1'b0;
        shutdown_pin_n_n_o = 1'b1;
    end
    // link clock stays low outside frames; a released data line flips
    task frame(input v);
        begin
            @(posedge sys_clk_i);
            cs_n_o <= v;
            if (v) din_o <= ~din_o;
        end
    endtask
    // link period of lo plus 4 cycles (80 ns when lo is 4); data set up in the low phase, ahead of the rise
    task clk_bit(input b, input integer lo);
        begin
            @(posedge sys_clk_i);
            din_o <= b;
            repeat (lo - 1) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            sclk_o <= 1'b0;
        end
    endtask
    // standby before converting after full power-down is left to the caller
    task send_byte(input [7:0] b);
        integer i;
        for (i = 7; i >= 0; i = i - 1) clk_bit(b[i], 4);
    endtask
    task read_bits(output [11:0] v);
        integer i;
        for (i = 0; i < 12; i = i + 1) begin
            clk_bit(1'b0, 8);
            // the falling edge reaches the pin only after the synchroniser
            repeat (8) @(posedge sys_clk_i);
            v = {v[10:0], dout_i};
        end
    endtask
    task shutdown(input v);
        begin
            @(posedge sys_clk_i);
            shutdown_pin_n_n_o <= v;
        end
    endtask
endmodule // apd_host_model

// ---- dv/testbench.sv ----
/* Self-checking bench for apd_core with a host model on the serial pins.
   Assumes a 100 MHz clock and a shortened internal conversion of 20 cycles. */
`timescale 1ns/1ns
module testbench;
    reg         sys_clk_i = 1'b0;
    reg         reset_i   = 1'b1;
    reg         psel_i;
    reg         penable_i;
    reg         pwrite_i;
    reg  [11:0] paddr_i;
    reg  [31:0] pwdata_i;
    wire [31:0] prdata_o;
    wire        pready_o, pslverr_o, chip_select_n_i, serial_clock_i, serial_data_in_i;
    wire        serial_data_out_o, serial_data_out_oe_o, conversion_strobe_o;
    wire        shutdown_pin_n_i, converter_en_o, bandgap_en_o, ref_buffer_en_o;
    integer     failures = 0;
    integer     cmp_count = 0;
    integer     i;
    reg  [31:0] rd;
    reg         err;
    reg  [11:0] bits;
    reg  [37:0] rows [0:6];
    always #5 sys_clk_i = ~sys_clk_i;
    apd_core #(.CONV_CYCLES(20)) apd_core_i (.sys_clk_i, .reset_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .chip_select_n_i,
        .serial_clock_i, .serial_data_in_i, .serial_data_out_o, .serial_data_out_oe_o,
        .conversion_strobe_o, .shutdown_pin_n_i, .converter_en_o, .bandgap_en_o,
        .ref_buffer_en_o);
    apd_host_model apd_host_model_i (.sys_clk_i, .cs_n_o(chip_select_n_i),
        .sclk_o(serial_clock_i), .din_o(serial_data_in_i), .shutdown_pin_n_n_o(shutdown_pin_n_i),
        .dout_i(serial_data_out_o));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_i);
            psel_i <= 1'b1;
            pwrite_i <= wr;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge sys_clk_i);
            penable_i <= 1'b1;
            do @(posedge sys_clk_i); while (pready_o !== 1'b1);
            rd = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    // external-clock conversions need link edges, so the wait clocks zeros
    task convert(input [15:0] s, input [2:0] ctl, input ext);
        begin
            apb(1'b1, 12'h004, {16'h0000, s});
            apd_host_model_i.frame(1'b0);
            apd_host_model_i.send_byte({5'b10000, ctl});
            // let the last rise pass the synchroniser so the strobe has fallen
            repeat (4) @(posedge sys_clk_i);
            while (conversion_strobe_o !== 1'b1)
                if (ext) apd_host_model_i.clk_bit(1'b0, 4);
                else @(posedge sys_clk_i);
            repeat (2) @(posedge sys_clk_i);
        end
    endtask
    task report_and_stop;
        begin
            if (failures == 0 && cmp_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        #500000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        psel_i    = 1'b0;
        penable_i = 1'b0;
        pwrite_i  = 1'b0;
        paddr_i   = 12'h000;
        pwdata_i  = 32'h00000000;
        // sample, ctl {bip, pd_high, pd_low}, code, status[6:0]
        rows[0] = {16'h0008, 3'b000, 12'h001, 7'h00};
        rows[1] = {16'h0007, 3'b001, 12'h000, 7'h24};
        rows[2] = {16'hFFFF, 3'b010, 12'hFFF, 7'h45};
        rows[3] = {16'hFFF8, 3'b111, 12'h000, 7'h76};
        rows[4] = {16'hFFF7, 3'b110, 12'hFFF, 7'h55};
        rows[5] = {16'h7FFF, 3'b110, 12'h7FF, 7'h55};
        rows[6] = {16'h8000, 3'b100, 12'h800, 7'h10};
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        check(32'({conversion_strobe_o, converter_en_o, bandgap_en_o, ref_buffer_en_o}), 32'hF);
        for (i = 0; i < 3; i = i + 1) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 12'h00C, 32'h0);
        check(32'({err, rd[30:0]}), 32'h80000000);
        apb(1'b1, 12'h000, 32'hFF);
        check(32'(err), 32'h1);
        for (i = 0; i < 7; i = i + 1) begin
            convert(rows[i][37:22], rows[i][21:19], rows[i][2]);
            apb(1'b0, 12'h008, 32'h0);
            check(rd, 32'(rows[i][18:7]));
            apb(1'b0, 12'h000, 32'h0);
            check(32'(rd[6:0]), 32'(rows[i][6:0]));
            check(32'({converter_en_o, ref_buffer_en_o}),
                32'({rows[i][1:0] == 2'h0, rows[i][1:0] != 2'h2}));
            apd_host_model_i.frame(1'b1);
        end
        // result shifted out while fully powered down
        convert(16'h5A50, 3'b011, 1'b0);
        check(32'({converter_en_o, ref_buffer_en_o}), 32'h0);
        apd_host_model_i.read_bits(bits);
        check(32'(bits), 32'h5A5);
        apd_host_model_i.frame(1'b1);
        // shutdown in mid conversion: aborted, result kept
        apb(1'b1, 12'h004, 32'h0100);
        apd_host_model_i.frame(1'b0);
        apd_host_model_i.send_byte(8'h80);
        apd_host_model_i.shutdown(1'b0);
        repeat (10) @(posedge sys_clk_i);
        check(32'({conversion_strobe_o, converter_en_o, ref_buffer_en_o}), 32'h4);
        apb(1'b0, 12'h000, 32'h0);
        check(32'({rd[7], rd[1:0]}), 32'h6);
        apd_host_model_i.shutdown(1'b1);
        repeat (10) @(posedge sys_clk_i);
        apb(1'b0, 12'h008, 32'h0);
        check(32'({converter_en_o, rd[11:0]}), 32'h5A5);
        apd_host_model_i.frame(1'b1);
        convert(16'h0100, 3'b000, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        check(32'({converter_en_o, rd[11:0]}), 32'h1010);
        report_and_stop;
    end
endmodule // testbench
bind apd_core apd_core_properties apd_core_properties_i (.sys_clk_i, .reset_i, .psel_i,
    .penable_i, .pready_o, .pslverr_o, .chip_select_n_i, .shutdown_pin_n_i,
    .serial_data_out_oe_o, .conversion_strobe_o, .converter_en_o, .bandgap_en_o,
    .ref_buffer_en_o);

// ---- hw/apd_core.v ----
/*
 * Power-down sequencing, serial control byte capture, conversion timing
 * and output coding of a 12-bit serial converter, with an APB view.
 * Assumes the serial pins and shutdown pin are asynchronous to sys_clk_i
 * and much slower than it; the analog input is modelled by the sample
 * register, written by software as an unsigned or signed 12.4 value.
 */
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "apd_regs.vh"

module apd_core #(
    parameter CONV_CYCLES   = `APD_CONV_CYCLES,
    parameter EXT_CONV_CLKS = `APD_EXT_CONV_CLKS
) (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        reset_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire        pready_o,
    output wire [31:0] prdata_o,
    output wire        pslverr_o,
    // serial pins
    input  wire        chip_select_n_i,
    input  wire        serial_clock_i,
    input  wire        serial_data_in_i,
    output wire        serial_data_out_o,
    output wire        serial_data_out_oe_o,
    output wire        conversion_strobe_o,
    // hardware shutdown pin
    input  wire        shutdown_pin_n_i,
    // analog power enables
    output wire        converter_en_o,
    output wire        bandgap_en_o,
    output wire        ref_buffer_en_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // pin synchronisers: index 0 select, 1 sclk, 2 din, 3 shutdown
    wire [3:0] pin_raw;
    reg  [3:0] sync1_q;
    reg  [3:0] sync2_q;
    reg  [3:0] sync3_q;
    reg  [3:0] pin_q;
    reg  [3:0] pin_prev_q;

    assign pin_raw = {shutdown_pin_n_i, serial_data_in_i,
                      serial_clock_i, chip_select_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk_i) begin
                if (reset_i) begin
                    sync1_q[gi]    <= 1'b1;
                    sync2_q[gi]    <= 1'b1;
                    sync3_q[gi]    <= 1'b1;
                    pin_q[gi]      <= 1'b1;
                    pin_prev_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi]    <= pin_raw[gi];
                    sync2_q[gi]    <= sync1_q[gi];
                    sync3_q[gi]    <= sync2_q[gi];
                    // a change counts only once two stages agree
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                    pin_prev_q[gi] <= pin_q[gi];
                end
            end
        end
    endgenerate

    wire cs_n     = pin_q[0];
    wire din      = pin_q[2];
    wire shutdown_pin_n_n   = pin_q[3];
    wire sclk_r   = pin_q[1] & ~pin_prev_q[1];
    wire sclk_f   = ~pin_q[1] & pin_prev_q[1];
    wire cs_fall  = ~pin_q[0] & pin_prev_q[0];
    wire rx_edge  = sclk_r & ~cs_n & shutdown_pin_n_n;
    wire tx_edge  = sclk_f & ~cs_n;

    // output coding with half-step rounding and saturation
    function [11:0] apd_encode;
        input [15:0] sample;
        input        bipolar;
        reg   [16:0] rnd;
        begin
            rnd = 17'h00000;
            if (bipolar) begin
                rnd = {sample[15], sample} + 17'h00008;     // [R13]
                if (rnd[16:15] == 2'b01) begin
                    apd_encode = 12'h7FF;
                end else begin
                    apd_encode = rnd[15:4];                 // [R12]
                end
            end else begin
                rnd = {1'b0, sample} + 17'h00008;           // [R13]
                if (rnd[16]) begin
                    apd_encode = 12'hFFF;
                end else begin
                    apd_encode = rnd[15:4];                 // [R11]
                end
            end
        end
    endfunction

    // serial and power state
    reg        state_q;
    reg [2:0]  rx_cnt_q;
    reg [6:0]  rx_shift_q;
    reg        receiving_q;
    reg [1:0]  pwr_q;
    reg        pd_high_q;
    reg        pd_low_q;
    reg        ext_clk_q;
    reg        bipolar_q;
    reg [11:0] conv_cnt_q;
    reg [11:0] result_q;
    reg [11:0] tx_shift_q;
    reg        dout_q;
    reg        dout_oe_q;
    reg        strobe_q;
    reg        conv_en_q;
    reg        bandgap_q;
    reg        refbuf_q;
    reg [15:0] sample_q;

    wire [7:0] ctrl_byte  = {rx_shift_q, din};
    wire       byte_done  = rx_edge & receiving_q & (rx_cnt_q == 3'h7);
    wire       conv_tick  = ext_clk_q ? rx_edge : 1'b1;
    wire       conv_done  = (state_q == ST_CONV) & conv_tick & (conv_cnt_q == 12'h001);

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q     <= ST_IDLE;                          // [R17]
            rx_cnt_q    <= 3'h0;
            rx_shift_q  <= 7'h00;
            receiving_q <= 1'b0;
            pwr_q       <= `APD_PWR_ACTIVE;                  // [R17]
            pd_high_q   <= 1'b0;
            pd_low_q    <= 1'b0;
            ext_clk_q   <= 1'b0;                             // [R17]
            bipolar_q   <= 1'b0;
            conv_cnt_q  <= 12'h000;
            result_q    <= `APD_RST_RESULT;                  // [R17]
            tx_shift_q  <= 12'h000;
        end else if (!shutdown_pin_n_n) begin
            // hardware shutdown wins over every other activity
            state_q     <= ST_IDLE;                          // [R6]
            receiving_q <= 1'b0;                             // [R19]
            rx_cnt_q    <= 3'h0;
            conv_cnt_q  <= 12'h000;
            pwr_q       <= `APD_PWR_FULL;                    // [R6]
        end else begin
            if (cs_n) begin
                receiving_q <= 1'b0;
                rx_cnt_q    <= 3'h0;
            end else if (rx_edge) begin
                if (!receiving_q) begin
                    if (din) begin
                        receiving_q <= 1'b1;                 // [R5]
                        rx_cnt_q    <= 3'h1;
                        rx_shift_q  <= 7'h01;
                        pwr_q       <= `APD_PWR_ACTIVE;      // [R5] [R8]
                    end
                end else begin
                    rx_shift_q <= ctrl_byte[6:0];
                    rx_cnt_q   <= rx_cnt_q + 3'h1;
                    if (rx_cnt_q == 3'h7) begin
                        receiving_q <= 1'b0;
                    end
                end
            end
            if (byte_done) begin
                // new byte replaces the held choice and restarts conversion
                pd_high_q  <= ctrl_byte[`APD_CB_PD_HIGH];    // [R18] [R1]
                pd_low_q   <= ctrl_byte[`APD_CB_PD_LOW];     // [R18]
                bipolar_q  <= ctrl_byte[`APD_CB_BIPOLAR];
                if (!ctrl_byte[`APD_CB_PD_HIGH]) begin
                    ext_clk_q <= ctrl_byte[`APD_CB_PD_LOW];  // [R16] [R14] [R15]
                end
                state_q    <= ST_CONV;
                if (ctrl_byte[`APD_CB_PD_HIGH] ? ext_clk_q : ctrl_byte[`APD_CB_PD_LOW]) begin
                    conv_cnt_q <= EXT_CONV_CLKS[11:0];
                end else begin
                    conv_cnt_q <= CONV_CYCLES[11:0];
                end
            end else if (conv_done) begin
                state_q    <= ST_IDLE;
                conv_cnt_q <= 12'h000;
                result_q   <= apd_encode(sample_q, bipolar_q);
                tx_shift_q <= apd_encode(sample_q, bipolar_q);
                // software power-down only at the end of conversion
                if (pd_high_q) begin                         // [R2] [R3] [R10]
                    pwr_q <= pd_low_q ? `APD_PWR_FULL : `APD_PWR_STANDBY;
                end else begin
                    pwr_q <= `APD_PWR_ACTIVE;                // [R3]
                end
            end else if ((state_q == ST_CONV) && conv_tick) begin
                conv_cnt_q <= conv_cnt_q - 12'h001;
            end
            // result shifting runs in every power state, but stops while the shutdown pin is held low
            if (tx_edge && !conv_done) begin
                tx_shift_q <= {tx_shift_q[10:0], 1'b0};      // [R4]
            end
        end
    end

    // serial output pins, driven whatever the power state
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
            strobe_q  <= 1'b1;
        end else begin
            dout_oe_q <= ~cs_n;
            if (cs_fall) begin
                dout_q <= 1'b0;
            end else if (tx_edge) begin
                dout_q <= tx_shift_q[11];                    // [R4]
            end
            // strobe low while converting, high once the result is ready
            strobe_q <= ~((state_q == ST_CONV) & ~conv_done) | ~shutdown_pin_n_n;
        end
    end

    // analog enables follow the power state
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            conv_en_q <= 1'b1;
            bandgap_q <= 1'b1;
            refbuf_q  <= 1'b1;
        end else begin
            conv_en_q <= (pwr_q == `APD_PWR_ACTIVE);
            bandgap_q <= 1'b1;                               // [R7] [R8]
            // standby keeps the buffer so the reference never droops
            refbuf_q  <= (pwr_q != `APD_PWR_FULL);           // [R7] [R8]
        end
    end

    // apb slave: one wait state, since read data comes from a flop
    reg        pready_q;
    reg [31:0] prdata_q;
    reg        pslverr_q;
    reg [31:0] rdata_d;
    reg        hit_d;

    wire access = psel_i & penable_i;

    always @* begin
        rdata_d = 32'h00000000;
        hit_d   = 1'b1;
        case (paddr_i)
            `APD_OFS_STATUS: begin
                rdata_d[`APD_ST_PWR_MSB:`APD_ST_PWR_LSB] = pwr_q;
                rdata_d[`APD_ST_EXT_CLK] = ext_clk_q;
                rdata_d[`APD_ST_BUSY]    = state_q;
                rdata_d[`APD_ST_BIPOLAR] = bipolar_q;
                rdata_d[`APD_ST_PD_LOW]  = pd_low_q;
                rdata_d[`APD_ST_PD_HIGH] = pd_high_q;
                rdata_d[`APD_ST_SHUTDOWN_PIN_N]    = ~shutdown_pin_n_n;
            end
            `APD_OFS_SAMPLE: begin
                rdata_d[15:0] = sample_q;
            end
            `APD_OFS_RESULT: begin
                rdata_d[11:0] = result_q;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            sample_q  <= `APD_RST_SAMPLE;
        end else begin
            pready_q  <= access & ~pready_q;
            if (access && !pready_q) begin
                prdata_q  <= pwrite_i ? 32'h00000000 : rdata_d;
                pslverr_q <= ~hit_d | (pwrite_i & (paddr_i != `APD_OFS_SAMPLE));
            end else begin
                pslverr_q <= 1'b0;
            end
            // the write lands at the edge where pready is sampled high
            if (access && pready_q && pwrite_i && (paddr_i == `APD_OFS_SAMPLE)) begin
                sample_q <= pwdata_i[15:0];
            end
        end
    end

    assign pready_o             = pready_q;
    assign prdata_o             = prdata_q;
    assign pslverr_o            = pslverr_q;
    assign serial_data_out_o    = dout_q;
    assign serial_data_out_oe_o = dout_oe_q;
    assign conversion_strobe_o  = strobe_q;
    assign converter_en_o       = conv_en_q;
    assign bandgap_en_o         = bandgap_q;
    assign ref_buffer_en_o      = refbuf_q;

endmodule // apd_core

// ---- shared/apd_regs.vh ----
/*
 * Constants of the converter power-down and output-coding block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit APB master.
 */
// Functional notes
// R1 - offer standby, full power-down and hardware shutdown, chosen by control byte bits; here hardware shutdown comes from the shutdown pin only
// R2 - a software power-down waits until the conversion of that byte ends
// R3 - upper bit zero keeps power on; one powers down at conversion end
// R4 - serial interface keeps working and shifts results during any power-down; here shifting stops while the shutdown pin is low
// R5 - first one on data-in after select falls starts and wakes device
// R6 - shutdown pin low forces full power-down at once and aborts conversion
// R7 - standby keeps bandgap and reference buffer enabled
// R8 - full power-down keeps only bandgap; buffer returns on power-up
// R9 - host runs a standby cycle and waits for reference recharge if needed
// R10 - standby in every byte powers down after each conversion, no wake delay
// R11 - unipolar results are straight binary, step is full scale over 4096
// R12 - bipolar results are two's complement, step is twice full scale over 4096
// R13 - code boundaries sit halfway between steps, rounding the input
// R14 - upper bit one, lower zero selects standby, clock mode unchanged
// R15 - both bits one select full power-down, clock mode unchanged
// R16 - upper bit zero: lower bit one external clock, zero internal clock
// R17 - after reset fully active, internal clock, idle, result cleared
// R18 - power-down choice of the last accepted byte is held until replaced
// R19 - on shutdown release go idle and wait for a start bit
`ifndef APD_REGS_VH
`define APD_REGS_VH

// register byte offsets
`define APD_OFS_STATUS      12'h000
`define APD_OFS_SAMPLE      12'h004
`define APD_OFS_RESULT      12'h008

// status fields
`define APD_ST_PWR_LSB      0
`define APD_ST_PWR_MSB      1
`define APD_ST_EXT_CLK      2
`define APD_ST_BUSY         3
`define APD_ST_BIPOLAR      4
`define APD_ST_PD_LOW       5
`define APD_ST_PD_HIGH      6
`define APD_ST_SHUTDOWN_PIN_N         7

// control byte fields
`define APD_CB_PD_LOW       0
`define APD_CB_PD_HIGH      1
`define APD_CB_BIPOLAR      2

// power states
`define APD_PWR_ACTIVE      2'h0
`define APD_PWR_STANDBY     2'h1
`define APD_PWR_FULL        2'h2

// reset values
`define APD_RST_SAMPLE      16'h0000
`define APD_RST_RESULT      12'h000

// timing
`define APD_SYS_CLK_MHZ     100
`define APD_CONV_TIME_NS    15000
`define APD_CONV_CYCLES     ((`APD_CONV_TIME_NS * `APD_SYS_CLK_MHZ) / 1000)
`define APD_EXT_CONV_CLKS   12

`endif
